// ---- acc_map.svh ----
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

// Register byte offsets
`define CALIBRATION_STATUS_OFS            8'h00
`define CALIBRATION_CONTROL_ONE_OFS          8'h04

// Status fields
`define CALIBRATION_STATUS_DONE_BIT       0
`define CALIBRATION_STATUS_LOST_BIT       1
`define CALIBRATION_STATUS_RST            32'h0000_0000

// First control register fields
`define CALIBRATION_CONTROL_ONE_EN_BIT       0
`define CALIBRATION_CONTROL_ONE_FINE_BIT     1
`define CALIBRATION_CONTROL_ONE_LOSS_IE_BIT  4
`define CALIBRATION_CONTROL_ONE_DONE_IE_BIT  5
`define CALIBRATION_CONTROL_ONE_STEP_LSB     8
`define CALIBRATION_CONTROL_ONE_STEP_MSB     11
`define CALIBRATION_CONTROL_ONE_RST          32'h0000_0100
`define ACC_STEP_RST           4'h1

// Sample window counts in divided oscillator cycles
`define ACC_CENTER_RST         16'h1F40
`define ACC_LOW_RST            16'h1F2C
`define ACC_HIGH_RST           16'h1F54
`define ACC_LOST_FACTOR        2

// Trim reset values
`define ACC_COARSE_RST         8'h80
`define ACC_FINE_RST           6'h20

`endif

// ---- acc_pkg.sv ----
package acc_pkg;

  typedef enum logic [1:0] {
    TRIM_HOLD,
    TRIM_UP,
    TRIM_DOWN
  } trim_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEARCH,
    ST_FIRST,
    ST_CROSS,
    ST_TRACK,
    ST_LOST
  } cal_state_t;

endpackage

// ---- acc_links.sv ----
`timescale 1ns/1ns
`default_nettype none

interface acc_meas_if #(parameter int unsigned CW = 16);
  logic          detect_en;
  logic [CW-1:0] lost_limit;
  logic [CW-1:0] period;
  logic          period_valid;
  logic          sof_seen;
  logic          lost;
  modport counter (input detect_en, lost_limit,
                   output period, period_valid, sof_seen, lost);
  modport ctrl    (output detect_en, lost_limit,
                   input period, period_valid, sof_seen, lost);
endinterface // acc_meas_if

interface acc_trim_if #(parameter int unsigned CALW = 8,
                        parameter int unsigned TRW = 6);
  acc_pkg::trim_cmd_t cmd;
  logic               fine_sel;
  logic [3:0]         step;
  logic [CALW-1:0]    coarse;
  logic [TRW-1:0]     fine;
  modport stepper (input cmd, fine_sel, step, output coarse, fine);
  modport ctrl    (output cmd, fine_sel, step, input coarse, fine);
endinterface // acc_trim_if

`default_nettype wire

// ---- acc_sample_counter.sv ----
`timescale 1ns/1ns
`default_nettype none

module acc_sample_counter #(
  parameter int unsigned CW = 16
) (
  input  wire logic     clk,
  input  wire logic     nrst,
  input  wire logic     osc_tick,
  input  wire logic     sof,
  acc_meas_if.counter   m
);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] period_q;
  logic          run_q;
  logic          sof_q;
  logic          valid_q;
  logic          seen_q;
  logic          lost_q;

  wire           sof_rise  = sof & ~sof_q & m.detect_en;
  wire [CW-1:0]  cnt_inc   = cnt_q + {{(CW-1){1'b0}}, 1'b1};
  wire           hit_limit = run_q & osc_tick & (cnt_inc >= m.lost_limit);

  assign m.period       = period_q;
  assign m.period_valid = valid_q;
  assign m.sof_seen     = seen_q;
  assign m.lost         = lost_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q    <= '0;
      period_q <= '0;
      run_q    <= 1'b0;
      sof_q    <= 1'b0;
      valid_q  <= 1'b0;
      seen_q   <= 1'b0;
      lost_q   <= 1'b0;
    end else begin
      sof_q   <= sof;
      valid_q <= sof_rise & run_q;
      seen_q  <= sof_rise;
      lost_q  <= hit_limit & ~sof_rise;
      if (!m.detect_en) begin
        cnt_q <= '0;
        run_q <= 1'b0;
      end else if (sof_rise) begin
        period_q <= cnt_q;
        cnt_q    <= '0;
        run_q    <= 1'b1;
      end else if (hit_limit) begin
        cnt_q <= '0;
        run_q <= 1'b0;
      end else if (run_q && osc_tick) begin
        cnt_q <= cnt_inc;
      end
    end
  end

endmodule // acc_sample_counter

`default_nettype wire

// ---- acc_trim_stepper.sv ----
`timescale 1ns/1ns
`default_nettype none

`include "acc_map.svh"

module acc_trim_stepper #(
  parameter int unsigned CALW = 8,
  parameter int unsigned TRW  = 6
) (
  input  wire logic     clk,
  input  wire logic     nrst,
  acc_trim_if.stepper   t
);

  if (CALW < 4 || TRW < 4) begin : g_chk
    $error("Trim widths must hold the step field");
  end

  logic [CALW-1:0] coarse_q;
  logic [TRW-1:0]  fine_q;

  wire           step_on = (t.step != 4'h0);
  wire           go_up   = step_on & (t.cmd == acc_pkg::TRIM_UP);
  wire           go_dn   = step_on & (t.cmd == acc_pkg::TRIM_DOWN);
  wire [CALW:0]  cal_up  = {1'b0, coarse_q} + {{(CALW-3){1'b0}}, t.step};
  wire [CALW:0]  cal_dn  = {1'b0, coarse_q} - {{(CALW-3){1'b0}}, t.step};
  wire [TRW:0]   tr_up   = {1'b0, fine_q} + {{(TRW-3){1'b0}}, t.step};
  wire [TRW:0]   tr_dn   = {1'b0, fine_q} - {{(TRW-3){1'b0}}, t.step};
  wire [CALW-1:0] cal_up_s = cal_up[CALW] ? '1 : cal_up[CALW-1:0];
  wire [CALW-1:0] cal_dn_s = cal_dn[CALW] ? '0 : cal_dn[CALW-1:0];
  wire [TRW-1:0]  tr_up_s  = tr_up[TRW] ? '1 : tr_up[TRW-1:0];
  wire [TRW-1:0]  tr_dn_s  = tr_dn[TRW] ? '0 : tr_dn[TRW-1:0];

  assign t.coarse = coarse_q;
  assign t.fine   = fine_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      coarse_q <= CALW'(`ACC_COARSE_RST);
      fine_q   <= TRW'(`ACC_FINE_RST);
    end else if (t.fine_sel) begin
      if (go_up) fine_q <= tr_up_s;
      else if (go_dn) fine_q <= tr_dn_s;
    end else begin
      if (go_up) coarse_q <= cal_up_s;
      else if (go_dn) coarse_q <= cal_dn_s;
    end
  end

endmodule // acc_trim_stepper

`default_nettype wire

// ---- acc_cal.sv ----

`timescale 1ns/1ns
`default_nettype none

`include "acc_map.svh"

module acc_cal #(
  parameter int unsigned   CW     = 16,
  parameter int unsigned   CALW   = 8,
  parameter int unsigned   TRW    = 6,
  parameter logic [CW-1:0] CENTER = CW'(`ACC_CENTER_RST),
  parameter logic [CW-1:0] LOW    = CW'(`ACC_LOW_RST),
  parameter logic [CW-1:0] HIGH   = CW'(`ACC_HIGH_RST)
) (
  input  wire logic            clk,
  input  wire logic            nrst,
  input  wire logic            osc_tick,
  input  wire logic            sof,
  input  wire logic [7:0]      addr,
  input  wire logic [31:0]     wdata,
  input  wire logic            wr,
  input  wire logic            rd,
  output logic      [31:0]     rdata,
  output logic                 irq,
  output logic      [CALW-1:0] coarse_cal_value,
  output logic      [TRW-1:0]  fine_trim_value
);

  if ((`ACC_LOST_FACTOR * CENTER) >= (2 ** CW) || LOW > CENTER ||
      HIGH < CENTER) begin : g_chk
    $error("Counter width or window bounds cannot serve");
  end

  localparam logic [CW-1:0] LOST_LIMIT = CW'(`ACC_LOST_FACTOR * CENTER);

  acc_meas_if #(.CW(CW)) meas ();
  acc_trim_if #(.CALW(CALW), .TRW(TRW)) trim ();

  acc_sample_counter #(
    .CW (CW)
  ) i_acc_sample_counter (
    .clk      (clk),
    .nrst     (nrst),
    .osc_tick (osc_tick),
    .sof      (sof),
    .m        (meas)
  );

  acc_trim_stepper #(
    .CALW (CALW),
    .TRW  (TRW)
  ) i_acc_trim_stepper (
    .clk  (clk),
    .nrst (nrst),
    .t    (trim)
  );

  // Control and status state
  logic                en_q;
  logic                fine_sel_q;
  logic                loss_ie_q;
  logic                done_ie_q;
  logic [3:0]          step_q;
  logic                done_q;
  logic                lost_q;
  logic                irq_q;
  logic [31:0]         rdata_q;
  acc_pkg::cal_state_t state_q;
  logic                dir_up_q;
  logic [CW-1:0]       prev_diff_q;

  // Next values
  logic                done_d;
  logic                lost_d;
  logic                irq_d;
  logic [31:0]         rdata_d;
  acc_pkg::cal_state_t state_d;
  logic                dir_up_d;
  logic [CW-1:0]       prev_diff_d;
  acc_pkg::trim_cmd_t  cmd;
  logic                set_done;
  logic                set_lost;

  // Bus decode
  wire sel_sts   = (addr == `CALIBRATION_STATUS_OFS);
  wire sel_ctrl  = (addr == `CALIBRATION_CONTROL_ONE_OFS);
  wire wr_sts    = wr & sel_sts;
  wire wr_ctrl   = wr & sel_ctrl;
  wire rd_sts    = rd & sel_sts;
  wire rd_ctrl   = rd & sel_ctrl;

  // Control write fields
  wire       en_w      = wdata[`CALIBRATION_CONTROL_ONE_EN_BIT];
  wire       fine_w    = wdata[`CALIBRATION_CONTROL_ONE_FINE_BIT];
  wire       loss_ie_w = wdata[`CALIBRATION_CONTROL_ONE_LOSS_IE_BIT];
  wire       done_ie_w = wdata[`CALIBRATION_CONTROL_ONE_DONE_IE_BIT];
  wire [3:0] step_w    = wdata[`CALIBRATION_CONTROL_ONE_STEP_MSB:`CALIBRATION_CONTROL_ONE_STEP_LSB];
  wire       en_fall   = wr_ctrl & ~en_w & en_q;
  wire       loss_ie_d = wr_ctrl ? loss_ie_w : loss_ie_q;
  wire       done_ie_d = wr_ctrl ? done_ie_w : done_ie_q;

  // Flag clears
  wire done_wr0 = wr_sts & ~wdata[`CALIBRATION_STATUS_DONE_BIT];
  wire lost_wr0 = wr_sts & ~wdata[`CALIBRATION_STATUS_LOST_BIT];
  wire done_clr = done_wr0 | rd_sts;
  wire lost_clr = lost_wr0 | rd_sts;

  // Read views
  wire [31:0] sts_view  = {30'h0, lost_q, done_q};
  wire [31:0] ctrl_view = {20'h0_0000, step_q, 2'b00, done_ie_q,
                           loss_ie_q, 2'b00, fine_sel_q, en_q};

  // Measurement evaluation
  wire [CW-1:0] period   = meas.period;
  wire          valid    = meas.period_valid;
  wire          below    = period < CENTER;
  wire          above    = period > CENTER;
  wire [CW-1:0] diff     = below ? (CENTER - period) : (period - CENTER);
  wire          on_mark  = ~below & ~above;
  wire          out_band = (period < LOW) | (period > HIGH);
  wire          crossed  = dir_up_q ? ~below : ~above;
  wire          go_back  = prev_diff_q < diff;
  wire          active   = (state_q == acc_pkg::ST_FIRST) |
                           (state_q == acc_pkg::ST_CROSS) |
                           (state_q == acc_pkg::ST_TRACK);

  assign meas.detect_en  = en_q;
  assign meas.lost_limit = LOST_LIMIT;
  assign trim.cmd        = cmd;
  assign trim.fine_sel   = fine_sel_q;
  assign trim.step       = step_q;

  // Calibration sequence
  always_comb begin
    state_d     = state_q;
    dir_up_d    = dir_up_q;
    prev_diff_d = prev_diff_q;
    cmd         = acc_pkg::TRIM_HOLD;
    set_done    = 1'b0;
    set_lost    = 1'b0;
    if (!en_q) begin
      state_d = acc_pkg::ST_IDLE;
    end else if (active && meas.lost) begin
      set_lost = 1'b1;
      state_d  = acc_pkg::ST_LOST;
    end else begin
      case (state_q)
        acc_pkg::ST_IDLE: begin
          state_d = acc_pkg::ST_SEARCH;
        end
        acc_pkg::ST_SEARCH, acc_pkg::ST_LOST: begin
          if (meas.sof_seen) begin
            state_d = acc_pkg::ST_FIRST;
          end
        end
        acc_pkg::ST_FIRST, acc_pkg::ST_TRACK: begin
          if (valid && (state_q == acc_pkg::ST_FIRST || out_band)) begin
            if (on_mark) begin
              set_done = 1'b1;
              state_d  = acc_pkg::ST_TRACK;
            end else begin
              dir_up_d    = below;
              prev_diff_d = diff;
              cmd         = below ? acc_pkg::TRIM_UP : acc_pkg::TRIM_DOWN;
              state_d     = acc_pkg::ST_CROSS;
            end
          end
        end
        acc_pkg::ST_CROSS: begin
          if (valid) begin
            if (crossed) begin
              if (go_back) begin
                cmd = dir_up_q ? acc_pkg::TRIM_DOWN : acc_pkg::TRIM_UP;
              end
              set_done = 1'b1;
              state_d  = acc_pkg::ST_TRACK;
            end else begin
              prev_diff_d = diff;
              cmd = dir_up_q ? acc_pkg::TRIM_UP : acc_pkg::TRIM_DOWN;
            end
          end
        end
        default: begin
          state_d = acc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Sticky flags: set wins over a software clear
  always_comb begin
    if (en_fall || !en_q) begin
      done_d = 1'b0;
      lost_d = 1'b0;
    end else begin
      done_d = set_done | (done_q & ~done_clr);
      lost_d = set_lost | (lost_q & ~lost_clr);
    end
  end

  assign irq_d = (done_d & done_ie_d) | (lost_d & loss_ie_d);

  assign rdata_d = rd_sts  ? sts_view  :
                   rd_ctrl ? ctrl_view : 32'h0000_0000;

  // Control register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      en_q       <= 1'b0;
      fine_sel_q <= 1'b0;
      loss_ie_q  <= 1'b0;
      done_ie_q  <= 1'b0;
      step_q     <= `ACC_STEP_RST;
    end else if (wr_ctrl) begin
      en_q       <= en_w;
      fine_sel_q <= fine_w;
      loss_ie_q  <= loss_ie_w;
      done_ie_q  <= done_ie_w;
      step_q     <= step_w;
    end
  end

  // Status, sequence and bus answer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      done_q      <= 1'b0;
      lost_q      <= 1'b0;
      irq_q       <= 1'b0;
      rdata_q     <= 32'h0000_0000;
      state_q     <= acc_pkg::ST_IDLE;
      dir_up_q    <= 1'b0;
      prev_diff_q <= '0;
    end else begin
      done_q      <= done_d;
      lost_q      <= lost_d;
      irq_q       <= irq_d;
      rdata_q     <= rdata_d;
      state_q     <= state_d;
      dir_up_q    <= dir_up_d;
      prev_diff_q <= prev_diff_d;
    end
  end

  assign rdata            = rdata_q;
  assign irq              = irq_q;
  assign coarse_cal_value = trim.coarse;
  assign fine_trim_value  = trim.fine;

endmodule // acc_cal

`default_nettype wire

// ---- acc_cal_checker.sv ----
`timescale 1ns/1ns
`default_nettype none

module acc_cal_checker #(
  parameter int unsigned CALW = 8,
  parameter int unsigned TRW  = 6
) (
  input wire logic            clk,
  input wire logic            nrst,
  input wire logic            osc_tick,
  input wire logic            sof,
  input wire logic [7:0]      addr,
  input wire logic [31:0]     wdata,
  input wire logic            wr,
  input wire logic            rd,
  input wire logic [31:0]     rdata,
  input wire logic            irq,
  input wire logic [CALW-1:0] coarse_cal_value,
  input wire logic [TRW-1:0]  fine_trim_value
);
  logic [31:0] ctrl_q;
  logic [2:0]  off_q;
  logic [2:0]  off_d;
  logic [2:0]  zero_q;
  logic [2:0]  zero_d;

  // Cycles since enable low / step zero, saturating at 4
  assign off_d  = ctrl_q[0] ? 3'h0 : (off_q == 3'h4) ? off_q : off_q + 3'h1;
  assign zero_d = (ctrl_q[11:8] != 4'h0) ? 3'h0 :
                  (zero_q == 3'h4) ? zero_q : zero_q + 3'h1;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= 32'h0000_0100;
      off_q  <= 3'h0;
      zero_q <= 3'h0;
    end else begin
      if (wr && addr == 8'h04) ctrl_q <= wdata & 32'h0000_0F33;
      off_q  <= off_d;
      zero_q <= zero_d;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  a_rdata_idle:
    assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data not zero outside read cycle");
  a_status_resv:
    assert property ($past(rd) && $past(addr) == 8'h00 |-> rdata[31:2] == 30'h0)
    else $error("status reserved bits not zero");
  a_ctrl_readback:
    assert property ($past(rd) && $past(addr) == 8'h04 |-> rdata == $past(ctrl_q))
    else $error("control read back wrong");
  a_off_hold:
    assert property (off_q == 3'h4 |->
                     $stable(coarse_cal_value) && $stable(fine_trim_value))
    else $error("trim moved while disabled");
  a_step_zero_hold:
    assert property (zero_q == 3'h4 |->
                     $stable(coarse_cal_value) && $stable(fine_trim_value))
    else $error("trim moved with zero step");
  a_fine_mode_only:
    assert property (ctrl_q[1] && $past(ctrl_q[1]) && $past(ctrl_q[1], 2)
                     |-> $stable(coarse_cal_value))
    else $error("coarse moved in fine mode");
  a_coarse_mode_only:
    assert property (!ctrl_q[1] && !$past(ctrl_q[1]) && !$past(ctrl_q[1], 2)
                     |-> $stable(fine_trim_value))
    else $error("fine moved in coarse mode");
  a_irq_masked:
    assert property (ctrl_q[5:4] == 2'h0 && $past(ctrl_q[5:4]) == 2'h0
                     |-> !irq)
    else $error("interrupt with both enables off");
endmodule // acc_cal_checker

bind acc_cal acc_cal_checker #(.CALW(CALW), .TRW(TRW)) i_acc_cal_checker (
  .clk(clk), .nrst(nrst), .osc_tick(osc_tick), .sof(sof), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
  .coarse_cal_value(coarse_cal_value), .fine_trim_value(fine_trim_value));

`default_nettype wire

// ---- sof_model.sv ----
`timescale 1ns/1ns
`default_nettype none

// Frame source plus oscillator: ticks per frame follow the trims
module sof_model (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       run,
  input  wire logic [7:0] base,
  input  wire logic [7:0] coarse,
  input  wire logic [5:0] fine,
  output logic            osc_tick,
  output logic            sof
);
  localparam int SOF_W = 12;
  int tick_q;
  int hi_q;
  int target;

  assign target = int'(base) + 8 * (int'(coarse) - 128) + 4 * (int'(fine) - 32);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      osc_tick <= 1'b0;
      sof      <= 1'b0;
      tick_q   <= 0;
      hi_q     <= 0;
    end else begin
      osc_tick <= !osc_tick;
      sof      <= hi_q != 0;
      if (hi_q != 0) hi_q <= hi_q - 1;
      if (osc_tick) tick_q <= tick_q + 1;
      if (run && osc_tick && tick_q + 1 >= target) begin
        tick_q <= 0;
        hi_q   <= SOF_W;
      end
    end
  end
endmodule // sof_model

`default_nettype wire

// ---- test_osc_auto_calibration_status.sv ----
`timescale 1ns/1ns
`default_nettype none

module test_osc_auto_calibration_status;
  logic        clk, nrst, osc_tick, sof, wr, rd, irq, run;
  logic [7:0]  addr, base, coarse, c_hi;
  logic [31:0] wdata, rdata, d;
  logic [5:0]  fine;
  int          n_tests, fail_count;

  acc_cal #(.CENTER(16'h0028), .LOW(16'h0024), .HIGH(16'h002C)) i_acc_cal (
    .clk(clk), .nrst(nrst), .osc_tick(osc_tick), .sof(sof), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
    .coarse_cal_value(coarse), .fine_trim_value(fine));
  sof_model i_sof_model (.clk(clk), .nrst(nrst), .run(run), .base(base),
    .coarse(coarse), .fine(fine), .osc_tick(osc_tick), .sof(sof));

  always #20 clk = !clk;

  task automatic end_sim;
    $display("tests %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic rd_check(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd_reg(a, v);
    check($sformatf("register %h", a), e, v);
  endtask
  task automatic wait_irq(input int lim);
    int i;
    c_hi = coarse;
    for (i = 0; i < lim && irq !== 1'b1; i++) begin
      @(posedge clk);
      #1 if (coarse > c_hi) c_hi = coarse;
    end
    if (irq !== 1'b1) begin
      fail_count++;
      $display("unexpected irq: expected 1 seen %b", irq);
      end_sim;
    end
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk);
    #1 check("irq", 32'(e), 32'(irq));
  endtask

  task automatic t_reset;
    rd_check(8'h00, 32'h0000_0000);
    rd_check(8'h04, 32'h0000_0100);
    rd_check(8'h08, 32'h0000_0000);
    check("coarse", 32'h0000_0080, 32'(coarse));
    check("fine", 32'h0000_0020, 32'(fine));
    $display("t_reset finished");
  endtask
  task automatic t_regs;
    wr_reg(8'h04, 32'hFFFF_FFFE);
    rd_check(8'h04, 32'h0000_0F32);
    wr_reg(8'h00, 32'hFFFF_FFFF);
    rd_check(8'h00, 32'h0000_0000);
    wr_reg(8'h08, 32'h0000_0000);
    rd_check(8'h04, 32'h0000_0F32);
    wr_reg(8'h04, 32'h0000_0100);
    $display("t_regs finished");
  endtask
  task automatic t_fine;
    base <= 8'h2F;
    wr_reg(8'h04, 32'h0000_0123);
    wait_irq(4000);
    check("fine", 32'h0000_001E, 32'(fine));
    check("coarse", 32'h0000_0080, 32'(coarse));
    wr_reg(8'h04, 32'h0000_0122);
    irq_is(1'b0);
    rd_check(8'h00, 32'h0000_0000);
    $display("t_fine finished");
  endtask
  task automatic t_coarse;
    base <= 8'h2E;
    wr_reg(8'h04, 32'h0000_0121);
    wait_irq(4000);
    check("coarse peak", 32'h0000_0081, 32'(c_hi));
    check("coarse", 32'h0000_0080, 32'(coarse));
    check("fine", 32'h0000_001E, 32'(fine));
    rd_check(8'h00, 32'h0000_0001);
    irq_is(1'b0);
    wr_reg(8'h04, 32'h0000_0120);
    $display("t_coarse finished");
  endtask
  task automatic t_step0;
    base <= 8'h1E;
    wr_reg(8'h04, 32'h0000_0021);
    repeat (800) @(posedge clk);
    check("coarse", 32'h0000_0080, 32'(coarse));
    check("fine", 32'h0000_001E, 32'(fine));
    irq_is(1'b0);
    wr_reg(8'h04, 32'h0000_0020);
    $display("t_step0 finished");
  endtask
  task automatic t_loss;
    base <= 8'h30;
    wr_reg(8'h04, 32'h0000_0111);
    repeat (300) @(posedge clk);
    rd_reg(8'h00, d);
    run <= 1'b0;
    wait_irq(1000);
    rd_check(8'h00, 32'h0000_0002);
    irq_is(1'b0);
    run <= 1'b1;
    repeat (300) @(posedge clk);
    rd_reg(8'h00, d);
    run <= 1'b0;
    wait_irq(1000);
    wr_reg(8'h00, 32'h0000_0000);
    irq_is(1'b0);
    repeat (400) @(posedge clk);
    irq_is(1'b0);
    wr_reg(8'h04, 32'h0000_0110);
    repeat (400) @(posedge clk);
    irq_is(1'b0);
    $display("t_loss finished");
  endtask

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    run = 1'b1;
    base = 8'h30;
    n_tests = 0;
    fail_count = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_regs;
    t_fine;
    t_coarse;
    t_step0;
    t_loss;
    end_sim;
  end
endmodule // test_osc_auto_calibration_status

`default_nettype wire
